// ---- core/mailbox_consts.svh ----
`ifndef MAILBOX_CONSTS_SVH
`define MAILBOX_CONSTS_SVH

// ****************************************************************
// geometry
// ****************************************************************
`define MB_DWIDTH       32
`define MB_DEPTH        16
`define MB_AWIDTH       4
`define MB_PTR_W        5
`define MB_MID_W        1
`define MB_MASTERS      2

// ****************************************************************
// register offsets within a memory-mapped side
// ****************************************************************
`define OFS_WRDATA      32'h00000000
`define OFS_RDDATA      32'h00000008
`define OFS_STATUS      32'h00000010
`define OFS_ERROR       32'h00000014
`define OFS_SPAN        32'h00000040

// ****************************************************************
// field positions and response codes
// ****************************************************************
`define STAT_EMPTY_BIT  0
`define STAT_FULL_BIT   1
`define ERR_EMPTY_BIT   0
`define ERR_FULL_BIT    1
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define RESP_DECERR     2'h3
`define SSIZE_32        2'h0
`define BUS_WORD_LAST   1'h1

`endif

// ---- core/mailbox_pkg.sv ----
`default_nettype none
`include "mailbox_consts.svh"

package mailbox_pkg;

	// interface option of one side
	typedef enum logic [2:0] {
		KIND_LB     = 3'h1,
		KIND_AXIL   = 3'h2,
		KIND_STREAM = 3'h4
	} iface_kind_t;

	// bus transaction phase of one side
	typedef enum logic [3:0] {
		BUS_IDLE = 4'h1,
		BUS_ACK  = 4'h2,
		BUS_DATA = 4'h4,
		BUS_RESP = 4'h8
	} bus_state_t;

	// register selected by an address
	typedef enum logic [2:0] {
		SEL_WRDATA, SEL_RDDATA, SEL_STATUS, SEL_ERROR, SEL_SPARE,
		SEL_UNMAPPED
	} reg_sel_t;

	typedef struct packed {
		logic                    last;
		logic [`MB_DWIDTH-1:0]   data;
	} word_t;

	typedef struct packed {
		logic [31:0]             addr;
		logic                    pa_valid;
		logic                    rnw;
		logic [`MB_MID_W-1:0]    master_id;
		logic [3:0]              be;
		logic [3:0]              size;
		logic [2:0]              xfer_type;
		logic [`MB_DWIDTH-1:0]   wdata;
	} lb_req_t;

	typedef struct packed {
		logic [31:0]             upper_addr;
		logic                    sa_valid;
		logic                    rd_prim;
		logic                    wr_prim;
		logic                    abort;
		logic                    bus_lock;
		logic [1:0]              msize;
		logic                    lock_err;
		logic                    wr_burst;
		logic                    rd_burst;
		logic                    wr_pend_req;
		logic                    rd_pend_req;
		logic [1:0]              wr_pend_pri;
		logic [1:0]              rd_pend_pri;
		logic [1:0]              req_pri;
		logic [15:0]             attribute;
	} lb_ignored_t;

	typedef struct packed {
		logic                    addr_ack;
		logic [1:0]              ssize;
		logic                    stall;
		logic                    rearbitrate;
		logic                    wr_dack;
		logic                    wr_comp;
		logic [`MB_DWIDTH-1:0]   rd_dbus;
		logic                    rd_dack;
		logic                    rd_comp;
		logic [`MB_MASTERS-1:0]  mbusy;
		logic [`MB_MASTERS-1:0]  mwr_err;
		logic [`MB_MASTERS-1:0]  mrd_err;
		logic                    wr_bterm;
		logic                    rd_bterm;
		logic [3:0]              unused_read_word_index;
		logic [`MB_MASTERS-1:0]  unused_master_irq_vector;
	} lb_rsp_t;

	typedef struct packed {
		logic [31:0]             awaddr;
		logic                    awvalid;
		logic [`MB_DWIDTH-1:0]   wdata;
		logic [3:0]              wstrb;
		logic                    wvalid;
		logic                    bready;
		logic [31:0]             araddr;
		logic                    arvalid;
		logic                    rready;
	} axil_req_t;

	typedef struct packed {
		logic                    awready;
		logic                    wready;
		logic [1:0]              bresp;
		logic                    bvalid;
		logic                    arready;
		logic [`MB_DWIDTH-1:0]   rdata;
		logic [1:0]              rresp;
		logic                    rvalid;
	} axil_rsp_t;

	typedef struct packed {
		logic [`MB_DWIDTH-1:0]   s_tdata;
		logic                    s_tlast;
		logic                    s_tvalid;
		logic                    m_tready;
	} axis_req_t;

	typedef struct packed {
		logic                    s_tready;
		logic [`MB_DWIDTH-1:0]   m_tdata;
		logic                    m_tlast;
		logic                    m_tvalid;
	} axis_rsp_t;

	// per-side bus state
	typedef struct packed {
		bus_state_t              phase;
		logic [31:0]             addr;
		logic [`MB_DWIDTH-1:0]   wdata;
		logic                    rnw;
		logic [`MB_MID_W-1:0]    mid;
		lb_rsp_t                 lb;
		axil_rsp_t               axi;
		logic                    s_tready;
		logic                    irq;
		logic [1:0]              err;
	} side_st_t;

	// per-direction fifo pointers and two-entry output buffer
	typedef struct packed {
		logic [`MB_PTR_W-1:0]    wptr;
		logic [`MB_PTR_W-1:0]    rptr;
		logic                    infl;
		logic [1:0]              bval;
		word_t [1:0]             bdat;
	} dir_st_t;

	typedef struct packed {
		side_st_t [1:0]          side;
		dir_st_t [1:0]           dir;
	} state_t;

	typedef struct packed {
		logic                    rdata_vld;
		word_t                   rdata;
	} store_st_t;

endpackage : mailbox_pkg

`default_nettype wire

// ---- core/word_store.sv ----
`default_nettype none
`include "mailbox_consts.svh"

module word_store (
	// clock
	input  wire  logic                     CLOCK,
	// write port
	input  wire  logic                     WR_EN,
	input  wire  logic [`MB_AWIDTH-1:0]    WR_ADDR,
	input  wire  mailbox_pkg::word_t       WR_WORD,
	// read port
	input  wire  logic                     RD_EN,
	input  wire  logic [`MB_AWIDTH-1:0]    RD_ADDR,
	output var   mailbox_pkg::word_t       RD_WORD
);
	mailbox_pkg::word_t     mem [`MB_DEPTH];
	mailbox_pkg::word_t     rd_word_ff;
	mailbox_pkg::word_t     nxt_rd_word;

	// read data comes out of a register, one cycle after RD_EN
	always_comb begin
		nxt_rd_word = rd_word_ff;
		if (RD_EN) begin
			nxt_rd_word = mem[RD_ADDR];
		end
	end

	// storage array and read register
	always_ff @(posedge CLOCK) begin
		if (WR_EN) begin
			mem[WR_ADDR] <= WR_WORD;
		end
		rd_word_ff <= nxt_rd_word;
	end

	assign RD_WORD = rd_word_ff;

endmodule : word_store

`default_nettype wire

// ---- core/dual_port_mailbox.sv ----
// Summary of operation
// - two sides, each option chosen at build time
// - same port set per side, index 0 or 1
// - local bus side reset active high
// - axi-lite side reset active low, synchronous
// - write response codes okay/slverr/decerr, reset zero
// - read response codes okay/slverr/decerr, reset zero
// - read address ready high after reset
// - other axi-lite handshakes low, read data zero
// - write strobes ignored, full word written
// - unused local bus inputs ignored
// - unused local bus outputs always zero
// - used local bus outputs zero after reset
// - stream option: input and output channels
// - stream outputs zero, input ready low, reset
// - word written one side read at other
// - per-side interrupt flags data available
`default_nettype none
`include "mailbox_consts.svh"

module dual_port_mailbox #(
	parameter mailbox_pkg::iface_kind_t SIDE0_KIND = mailbox_pkg::KIND_AXIL,
	parameter mailbox_pkg::iface_kind_t SIDE1_KIND = mailbox_pkg::KIND_STREAM
) (
	// clock and reset
	input  wire  logic                               CLOCK,
	input  wire  logic                               RESET_N,
	// local bus option
	input  wire  logic [1:0]                         LB_RESET,
	input  wire  mailbox_pkg::lb_req_t [1:0]         LB_REQ,
	input  wire  mailbox_pkg::lb_ignored_t [1:0]     LB_IGNORED,
	output var   mailbox_pkg::lb_rsp_t [1:0]         LB_RSP,
	// axi-lite option
	input  wire  logic [1:0]                         AXIL_RESET_N,
	input  wire  mailbox_pkg::axil_req_t [1:0]       AXIL_REQ,
	output var   mailbox_pkg::axil_rsp_t [1:0]       AXIL_RSP,
	// stream option
	input  wire  mailbox_pkg::axis_req_t [1:0]       AXIS_REQ,
	output var   mailbox_pkg::axis_rsp_t [1:0]       AXIS_RSP,
	// data available per side
	output var   logic [1:0]                         INTERRUPT
);
	// ****************************************************************
	// build-time options
	// ****************************************************************
	localparam mailbox_pkg::iface_kind_t KIND [2] = '{SIDE0_KIND, SIDE1_KIND};
	localparam logic [`MB_PTR_W-1:0] DEPTH_CNT = `MB_PTR_W'(`MB_DEPTH);

	// address decode shared by reads and writes on both sides
	function automatic mailbox_pkg::reg_sel_t decode(input logic [31:0] a);
		if (a >= `OFS_SPAN) begin
			return mailbox_pkg::SEL_UNMAPPED;
		end
		unique case (a)
			`OFS_WRDATA: return mailbox_pkg::SEL_WRDATA;
			`OFS_RDDATA: return mailbox_pkg::SEL_RDDATA;
			`OFS_STATUS: return mailbox_pkg::SEL_STATUS;
			`OFS_ERROR:  return mailbox_pkg::SEL_ERROR;
			default:     return mailbox_pkg::SEL_SPARE;
		endcase
	endfunction : decode

	// words waiting in the store of one direction
	function automatic logic [`MB_PTR_W-1:0] fill(
		input mailbox_pkg::dir_st_t d);
		return `MB_PTR_W'(d.wptr - d.rptr);
	endfunction : fill

	// reset value of one side
	function automatic mailbox_pkg::side_st_t init_side(input int s);
		mailbox_pkg::side_st_t v;
		v = '0;
		v.phase = mailbox_pkg::BUS_IDLE;
		v.axi.arready = (KIND[s] == mailbox_pkg::KIND_AXIL);
		return v;
	endfunction : init_side

	function automatic mailbox_pkg::state_t init_state();
		mailbox_pkg::state_t v;
		v = '0;
		v.side[0] = init_side(0);
		v.side[1] = init_side(1);
		return v;
	endfunction : init_state

	localparam mailbox_pkg::state_t RST_STATE = init_state();

	// ****************************************************************
	// state and store ports
	// ****************************************************************
	mailbox_pkg::state_t                  state_ff;
	mailbox_pkg::state_t                  nxt_state;
	logic [1:0]                           mem_wr;
	logic [1:0]                           mem_rd;
	logic [1:0][`MB_AWIDTH-1:0]           mem_waddr;
	logic [1:0][`MB_AWIDTH-1:0]           mem_raddr;
	mailbox_pkg::word_t [1:0]             mem_wword;
	mailbox_pkg::word_t [1:0]             mem_rword;
	logic [1:0]                           push;
	logic [1:0]                           pop;
	mailbox_pkg::word_t [1:0]             push_word;

	// one store per direction: side d writes, side 1-d reads
	for (genvar d = 0; d < 2; d++) begin : g_store
		word_store u_store (
			.CLOCK   (CLOCK),
			.WR_EN   (mem_wr[d]),
			.WR_ADDR (mem_waddr[d]),
			.WR_WORD (mem_wword[d]),
			.RD_EN   (mem_rd[d]),
			.RD_ADDR (mem_raddr[d]),
			.RD_WORD (mem_rword[d])
		);
	end

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		logic                     wr_go;
		logic                     rd_go;
		logic                     side_rst;
		logic [31:0]              acc_addr;
		logic [`MB_DWIDTH-1:0]    acc_data;
		logic [`MB_DWIDTH-1:0]    rd_val;
		logic [1:0]               resp;
		logic [1:0]               err_set;
		logic [1:0]               err_clr;
		logic                     bad;
		mailbox_pkg::dir_st_t     dn;
		wr_go = 1'b0;
		rd_go = 1'b0;
		side_rst = 1'b0;
		acc_addr = '0;
		acc_data = '0;
		rd_val = '0;
		resp = `RESP_OKAY;
		err_set = '0;
		err_clr = '0;
		bad = 1'b0;
		dn = '0;
		nxt_state = state_ff;
		mem_wr = '0;
		mem_rd = '0;
		mem_waddr = '0;
		mem_raddr = '0;
		mem_wword = '0;
		push = '0;
		pop = '0;
		push_word = '0;
		for (int s = 0; s < 2; s++) begin
			wr_go = 1'b0;
			rd_go = 1'b0;
			acc_addr = '0;
			acc_data = '0;
			rd_val = '0;
			resp = `RESP_OKAY;
			err_set = '0;
			err_clr = '0;
			bad = 1'b0;
			side_rst = 1'b0;
			// access moment of each bus option
			unique case (KIND[s])
				mailbox_pkg::KIND_LB: begin
					side_rst = LB_RESET[s];
					wr_go = (state_ff.side[s].phase == mailbox_pkg::BUS_ACK)
						&& !state_ff.side[s].rnw;
					rd_go = (state_ff.side[s].phase == mailbox_pkg::BUS_ACK)
						&& state_ff.side[s].rnw;
					acc_addr = state_ff.side[s].addr;
					acc_data = state_ff.side[s].wdata;
				end
				mailbox_pkg::KIND_AXIL: begin
					side_rst = !AXIL_RESET_N[s];
					wr_go = state_ff.side[s].phase == mailbox_pkg::BUS_ACK;
					rd_go = (state_ff.side[s].phase == mailbox_pkg::BUS_IDLE)
						&& AXIL_REQ[s].arvalid;
					acc_addr = wr_go ? AXIL_REQ[s].awaddr : AXIL_REQ[s].araddr;
					acc_data = AXIL_REQ[s].wdata;
				end
				mailbox_pkg::KIND_STREAM: begin
					if (AXIS_REQ[s].s_tvalid && state_ff.side[s].s_tready) begin
						push[s] = 1'b1;
						push_word[s] = {AXIS_REQ[s].s_tlast, AXIS_REQ[s].s_tdata};
					end
					pop[1-s] = state_ff.dir[1-s].bval[0]
						&& AXIS_REQ[s].m_tready;
				end
			endcase
			// register access shared by both memory-mapped options
			if (wr_go) begin
				unique case (decode(acc_addr))
					mailbox_pkg::SEL_WRDATA: begin
						if (fill(state_ff.dir[s]) == DEPTH_CNT) begin
							resp = `RESP_SLVERR;
							err_set[`ERR_FULL_BIT] = 1'b1;
						end else begin
							push[s] = 1'b1;
							push_word[s] = {`BUS_WORD_LAST, acc_data};
						end
					end
					mailbox_pkg::SEL_UNMAPPED: resp = `RESP_DECERR;
					default: resp = `RESP_OKAY;
				endcase
			end
			if (rd_go) begin
				unique case (decode(acc_addr))
					mailbox_pkg::SEL_RDDATA: begin
						if (state_ff.dir[1-s].bval[0]) begin
							pop[1-s] = 1'b1;
							rd_val = state_ff.dir[1-s].bdat[0].data;
						end else begin
							resp = `RESP_SLVERR;
							err_set[`ERR_EMPTY_BIT] = 1'b1;
						end
					end
					mailbox_pkg::SEL_STATUS: begin
						rd_val[`STAT_EMPTY_BIT] = !state_ff.dir[1-s].bval[0];
						rd_val[`STAT_FULL_BIT] = fill(state_ff.dir[s]) == DEPTH_CNT;
					end
					mailbox_pkg::SEL_ERROR: begin
						rd_val = `MB_DWIDTH'(state_ff.side[s].err);
						err_clr = 2'h3;
					end
					mailbox_pkg::SEL_UNMAPPED: resp = `RESP_DECERR;
					default: rd_val = '0;
				endcase
			end
			bad = resp != `RESP_OKAY;
			// error flags: a new error wins over the clear by read
			nxt_state.side[s].err = (state_ff.side[s].err & ~err_clr) | err_set;
			// bus handshakes; unused local bus inputs never looked at
			unique case (KIND[s])
				mailbox_pkg::KIND_LB: begin
					unique case (state_ff.side[s].phase)
						mailbox_pkg::BUS_IDLE: begin
							if (LB_REQ[s].pa_valid) begin
								nxt_state.side[s].phase = mailbox_pkg::BUS_ACK;
								nxt_state.side[s].addr = LB_REQ[s].addr;
								nxt_state.side[s].rnw = LB_REQ[s].rnw;
								nxt_state.side[s].wdata = LB_REQ[s].wdata;
								nxt_state.side[s].mid = LB_REQ[s].master_id;
								nxt_state.side[s].lb.addr_ack = 1'b1;
								nxt_state.side[s].lb.mbusy[LB_REQ[s].master_id] = 1'b1;
							end
						end
						mailbox_pkg::BUS_ACK: begin
							nxt_state.side[s].phase = mailbox_pkg::BUS_DATA;
							nxt_state.side[s].lb.addr_ack = 1'b0;
							nxt_state.side[s].lb.wr_dack = wr_go;
							nxt_state.side[s].lb.wr_comp = wr_go;
							nxt_state.side[s].lb.rd_dack = rd_go;
							nxt_state.side[s].lb.rd_comp = rd_go;
							nxt_state.side[s].lb.rd_dbus = rd_val;
							nxt_state.side[s].lb.mwr_err[state_ff.side[s].mid] =
								wr_go && bad;
							nxt_state.side[s].lb.mrd_err[state_ff.side[s].mid] =
								rd_go && bad;
						end
						default: begin
							nxt_state.side[s].phase = mailbox_pkg::BUS_IDLE;
							nxt_state.side[s].lb = '0;
						end
					endcase
				end
				mailbox_pkg::KIND_AXIL: begin
					unique case (state_ff.side[s].phase)
						mailbox_pkg::BUS_IDLE: begin
							if (rd_go) begin
								nxt_state.side[s].phase = mailbox_pkg::BUS_RESP;
								nxt_state.side[s].axi.arready = 1'b0;
								nxt_state.side[s].axi.rvalid = 1'b1;
								nxt_state.side[s].axi.rdata = rd_val;
								nxt_state.side[s].axi.rresp = resp;
							end else if (AXIL_REQ[s].awvalid && AXIL_REQ[s].wvalid) begin
								nxt_state.side[s].phase = mailbox_pkg::BUS_ACK;
								nxt_state.side[s].axi.arready = 1'b0;
								nxt_state.side[s].axi.awready = 1'b1;
								nxt_state.side[s].axi.wready = 1'b1;
							end
						end
						mailbox_pkg::BUS_ACK: begin
							nxt_state.side[s].phase = mailbox_pkg::BUS_RESP;
							nxt_state.side[s].axi.awready = 1'b0;
							nxt_state.side[s].axi.wready = 1'b0;
							nxt_state.side[s].axi.bvalid = 1'b1;
							nxt_state.side[s].axi.bresp = resp;
						end
						default: begin
							if ((state_ff.side[s].axi.rvalid && AXIL_REQ[s].rready)
								|| (state_ff.side[s].axi.bvalid
								&& AXIL_REQ[s].bready)) begin
								nxt_state.side[s].phase = mailbox_pkg::BUS_IDLE;
								nxt_state.side[s].axi = RST_STATE.side[s].axi;
							end
						end
					endcase
				end
				default: begin
					nxt_state.side[s].phase = mailbox_pkg::BUS_IDLE;
				end
			endcase
			if (side_rst) begin
				nxt_state.side[s] = init_side(s);
			end
		end
		// store pointers and two-entry output buffer per direction
		for (int d = 0; d < 2; d++) begin
			dn = state_ff.dir[d];
			if (pop[d]) begin
				dn.bdat[0] = dn.bdat[1];
				dn.bval = {1'b0, dn.bval[1]};
			end
			if (state_ff.dir[d].infl) begin
				if (!dn.bval[0]) begin
					dn.bdat[0] = mem_rword[d];
					dn.bval[0] = 1'b1;
				end else begin
					dn.bdat[1] = mem_rword[d];
					dn.bval[1] = 1'b1;
				end
			end
			// fetch only while a buffer slot is sure to be free
			dn.infl = (fill(state_ff.dir[d]) != '0) && !dn.bval[1];
			mem_rd[d] = dn.infl;
			mem_raddr[d] = state_ff.dir[d].rptr[`MB_AWIDTH-1:0];
			if (dn.infl) begin
				dn.rptr = `MB_PTR_W'(state_ff.dir[d].rptr + 1'b1);
			end
			mem_wr[d] = push[d];
			mem_waddr[d] = state_ff.dir[d].wptr[`MB_AWIDTH-1:0];
			mem_wword[d] = push_word[d];
			if (push[d]) begin
				dn.wptr = `MB_PTR_W'(state_ff.dir[d].wptr + 1'b1);
			end
			nxt_state.dir[d] = dn;
		end
		// stream ready follows the updated fill level, interrupts the updated output buffer
		for (int s = 0; s < 2; s++) begin
			nxt_state.side[s].s_tready = (KIND[s] == mailbox_pkg::KIND_STREAM)
				&& (fill(nxt_state.dir[s]) != DEPTH_CNT);
			nxt_state.side[s].irq = nxt_state.dir[1-s].bval[0];
		end
	end

	// state register
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff <= RST_STATE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	for (genvar s = 0; s < 2; s++) begin : g_out
		localparam logic IS_STREAM = KIND[s] == mailbox_pkg::KIND_STREAM;
		assign LB_RSP[s] = state_ff.side[s].lb;
		assign AXIL_RSP[s] = state_ff.side[s].axi;
		assign AXIS_RSP[s].s_tready = state_ff.side[s].s_tready;
		assign AXIS_RSP[s].m_tvalid = IS_STREAM
			&& state_ff.dir[1-s].bval[0];
		assign AXIS_RSP[s].m_tdata = IS_STREAM
			? state_ff.dir[1-s].bdat[0].data : '0;
		assign AXIS_RSP[s].m_tlast = IS_STREAM
			&& state_ff.dir[1-s].bdat[0].last;
		assign INTERRUPT[s] = state_ff.side[s].irq;
	end

endmodule : dual_port_mailbox

`default_nettype wire

// ---- testbench/mailbox_props.sv ----
`default_nettype none
`include "mailbox_consts.svh"

module mailbox_props (
	// clock and reset
	input wire logic                           CLOCK,
	input wire logic                           RESET_N,
	// local bus
	input wire logic [1:0]                     LB_RESET,
	input wire mailbox_pkg::lb_req_t [1:0]     LB_REQ,
	input wire mailbox_pkg::lb_ignored_t [1:0] LB_IGNORED,
	input wire mailbox_pkg::lb_rsp_t [1:0]     LB_RSP,
	// axi-lite
	input wire logic [1:0]                     AXIL_RESET_N,
	input wire mailbox_pkg::axil_req_t [1:0]   AXIL_REQ,
	input wire mailbox_pkg::axil_rsp_t [1:0]   AXIL_RSP,
	// stream and interrupt
	input wire mailbox_pkg::axis_req_t [1:0]   AXIS_REQ,
	input wire mailbox_pkg::axis_rsp_t [1:0]   AXIS_RSP,
	input wire logic [1:0]                     INTERRUPT
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam mailbox_pkg::axil_rsp_t IDLE = '{arready: 1'b1, default: '0};
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	// ****
	// checks on side 0 bus, side 1 stream and the unused outputs of both sides
	// ****
	rst_axil_a: assert property ($rose(RESET_N) |-> AXIL_RSP[0] == IDLE)
		else $error("bus outputs wrong after reset");
	rst_stream_a: assert property ($rose(RESET_N) |-> AXIS_RSP == '0 && INTERRUPT == 2'h0)
		else $error("stream outputs wrong after reset");
	side_reset_a: assert property (!AXIL_RESET_N[0] |=> AXIL_RSP[0] == IDLE)
		else $error("side reset not honoured");
	bresp_code_a: assert property (AXIL_RSP[0].bvalid |-> AXIL_RSP[0].bresp != 2'h1)
		else $error("bad write response code");
	rresp_code_a: assert property (AXIL_RSP[0].rvalid |-> AXIL_RSP[0].rresp != 2'h1 && (AXIL_RSP[0].rresp == `RESP_OKAY || AXIL_RSP[0].rdata == '0))
		else $error("bad read response");
	read_lat_a: assert property (AXIL_REQ[0].arvalid && AXIL_RSP[0].arready |=> AXIL_RSP[0].rvalid && !AXIL_RSP[0].arready)
		else $error("read answer late");
	read_hold_a: assert property (AXIL_RSP[0].rvalid && !AXIL_REQ[0].rready |=> AXIL_RSP[0].rvalid && $stable(AXIL_RSP[0].rdata) && $stable(AXIL_RSP[0].rresp))
		else $error("read answer dropped");
	write_seq_a: assert property (AXIL_RSP[0].awready |-> AXIL_RSP[0].wready ##1 (!AXIL_RSP[0].awready && AXIL_RSP[0].bvalid))
		else $error("write handshake order");
	lb_quiet_a: assert property (LB_RSP == '0 && AXIL_RSP[1] == '0 && AXIS_RSP[0] == '0)
		else $error("unused outputs not zero");
	stream_hold_a: assert property (AXIS_RSP[1].m_tvalid && !AXIS_REQ[1].m_tready |=> AXIS_RSP[1].m_tvalid && $stable(AXIS_RSP[1].m_tdata))
		else $error("stream word lost");
	irq_level_a: assert property ($rose(AXIS_RSP[1].m_tvalid) |-> ##[0:1] INTERRUPT[1])
		else $error("interrupt missing");
	cover property (AXIL_RSP[0].bvalid && AXIL_RSP[0].bresp == `RESP_SLVERR);
	cover property (AXIL_RSP[0].rvalid && AXIL_RSP[0].rresp == `RESP_DECERR);
	cover property (AXIS_RSP[1].m_tvalid && !AXIS_REQ[1].m_tready);
endmodule : mailbox_props

bind dual_port_mailbox mailbox_props props_u (.CLOCK(CLOCK), .RESET_N(RESET_N),
	.LB_RESET(LB_RESET), .LB_REQ(LB_REQ), .LB_IGNORED(LB_IGNORED),
	.LB_RSP(LB_RSP), .AXIL_RESET_N(AXIL_RESET_N), .AXIL_REQ(AXIL_REQ),
	.AXIL_RSP(AXIL_RSP), .AXIS_REQ(AXIS_REQ), .AXIS_RSP(AXIS_RSP),
	.INTERRUPT(INTERRUPT));

`default_nettype wire

// ---- testbench/stream_peer.sv ----
`default_nettype none

module stream_peer #(
	parameter int N_SEND = 4
) (
	// clock and reset
	input wire logic                   clock,
	input wire logic                   reset_n,
	// control from the bench
	input wire logic                   go,
	input wire logic                   stall,
	// stream pair facing the device
	input wire mailbox_pkg::axis_rsp_t rsp,
	output var mailbox_pkg::axis_req_t req
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] PATTERN = 32'hA5C30000;
	integer seed = 60434;
	initial req = '0;
	// sink: random stalls, fully held off while stall is up
	always @(posedge clock) req.m_tready <= #1 reset_n & ~stall & ($random(seed) > 0);
	// source: each word held until the device takes it
	always begin
		@(posedge clock iff go === 1'b1);
		for (int i = 0; i < N_SEND; i++) begin
			#1;
			req.s_tdata = PATTERN + i;
			req.s_tlast = (i == N_SEND - 1);
			req.s_tvalid = 1'b1;
			do @(negedge clock); while (rsp.s_tready !== 1'b1);
			@(posedge clock);
		end
		#1;
		req.s_tvalid = 1'b0;
		req.s_tdata = ~req.s_tdata; // released line shows no stale word
	end
endmodule : stream_peer

`default_nettype wire

// ---- testbench/test_dual_port_mailbox.sv ----
`default_nettype none
`include "mailbox_consts.svh"

module test_dual_port_mailbox;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] PATTERN = 32'hA5C30000;
	logic                           clock;
	logic                           reset_n;
	logic [1:0]                     axil_reset_n;
	logic                           go;
	logic                           stall;
	logic [1:0]                     interrupt;
	mailbox_pkg::lb_ignored_t [1:0] lb_ignored;
	mailbox_pkg::lb_rsp_t [1:0]     lb_rsp;
	mailbox_pkg::axil_req_t         am;
	mailbox_pkg::axil_rsp_t [1:0]   axil_rsp;
	mailbox_pkg::axis_req_t         peer_req;
	mailbox_pkg::axis_rsp_t [1:0]   axis_rsp;
	logic [33:0]                    aq[$];
	mailbox_pkg::word_t             sq[$];
	integer                         seed = 60434;
	int                             n_errors = 0;
	int                             n_compared = 0;
	int                             k;

	dual_port_mailbox dut_u (.CLOCK(clock), .RESET_N(reset_n),
		.LB_RESET(2'h0), .LB_REQ('0), .LB_IGNORED(lb_ignored), .LB_RSP(lb_rsp),
		.AXIL_RESET_N(axil_reset_n),
		.AXIL_REQ({mailbox_pkg::axil_req_t'(0), am}), .AXIL_RSP(axil_rsp),
		.AXIS_REQ({peer_req, mailbox_pkg::axis_req_t'(0)}),
		.AXIS_RSP(axis_rsp), .INTERRUPT(interrupt));
	stream_peer #(.N_SEND(4)) peer_u (.clock(clock), .reset_n(reset_n),
		.go(go), .stall(stall), .rsp(axis_rsp[1]), .req(peer_req));

	// clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// random ignored inputs and response readiness
	always @(posedge clock) begin
		lb_ignored <= #1 132'({$random(seed), $random(seed), $random(seed),
			$random(seed), $random(seed)});
		am.bready <= #1 ($random(seed) % 3 != 0);
		am.rready <= #1 ($random(seed) % 3 != 0);
	end
	// compare tasks
	task automatic chk_axi(input logic [33:0] got);
		logic [33:0] exp;
		exp = aq.pop_front();
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: bus got %h want %h", $time, got, exp);
		end
	endtask : chk_axi
	task automatic chk_word(input mailbox_pkg::word_t got);
		mailbox_pkg::word_t exp;
		exp = sq.pop_front();
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: word got %h want %h", $time, got, exp);
		end
	endtask : chk_word
	// one bus transaction, expected answer noted first
	task automatic axi(input logic wr, input logic [31:0] addr,
		input logic [31:0] data, input logic [1:0] resp);
		aq.push_back({resp, wr ? 32'h0 : data});
		@(posedge clock);
		#1;
		am.awaddr = addr;
		am.araddr = addr;
		am.wdata = data;
		am.wstrb = 4'($random(seed));
		am.awvalid = wr;
		am.wvalid = wr;
		am.arvalid = !wr;
		do @(negedge clock); while ((wr ? axil_rsp[0].awready : axil_rsp[0].arready) !== 1'b1);
		@(posedge clock);
		#1;
		am.awvalid = 1'b0;
		am.wvalid = 1'b0;
		am.arvalid = 1'b0;
		am.wdata = ~data;
		do @(negedge clock); while ((wr ? axil_rsp[0].bvalid & am.bready : axil_rsp[0].rvalid & am.rready) !== 1'b1);
		@(posedge clock);
	endtask : axi
	// watcher of results
	always @(negedge clock) begin
		if (axil_rsp[0].rvalid === 1'b1 && am.rready === 1'b1)
			chk_axi({axil_rsp[0].rresp, axil_rsp[0].rdata});
		if (axil_rsp[0].bvalid === 1'b1 && am.bready === 1'b1)
			chk_axi({axil_rsp[0].bresp, 32'h0});
		if (axis_rsp[1].m_tvalid === 1'b1 && peer_req.m_tready === 1'b1)
			chk_word({axis_rsp[1].m_tlast, axis_rsp[1].m_tdata});
	end
	// verdict
	task automatic final_report;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	// watchdog
	initial begin
		#100000;
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		final_report();
	end
	// main sequence
	initial begin
		am = '0;
		reset_n = 1'b0;
		axil_reset_n = 2'h0;
		go = 1'b0;
		stall = 1'b0;
		repeat (16) @(posedge clock);
		#1;
		reset_n = 1'b1;
		axil_reset_n = 2'h3;
		axi(0, `OFS_RDDATA, 32'h0, `RESP_SLVERR);
		axi(0, `OFS_ERROR, 32'h1, `RESP_OKAY);
		axi(0, `OFS_STATUS, 32'h1, `RESP_OKAY);
		axi(0, `OFS_SPAN, 32'h0, `RESP_DECERR);
		axi(1, `OFS_SPAN + 32'h4, 32'h0, `RESP_DECERR);
		axi(1, `OFS_RDDATA, 32'h0, `RESP_OKAY);
		stall = 1'b1;
		for (int i = 0; i < 19; i++) begin
			k = $random(seed);
			if (i < 18)
				sq.push_back({1'b1, 32'(k)});
			axi(1, `OFS_WRDATA, 32'(k), i < 18 ? `RESP_OKAY : `RESP_SLVERR);
		end
		axi(0, `OFS_STATUS, 32'h3, `RESP_OKAY);
		axi(0, `OFS_ERROR, 32'h2, `RESP_OKAY);
		stall = 1'b0;
		for (k = 0; k < 400 && sq.size() > 0; k++) @(posedge clock);
		go = 1'b1;
		@(posedge clock);
		#1;
		go = 1'b0;
		for (int i = 0; i < 4; i++) begin
			for (k = 0; k < 50 && interrupt[0] !== 1'b1; k++) @(negedge clock);
			axi(0, `OFS_RDDATA, PATTERN + i, `RESP_OKAY);
		end
		axi(0, `OFS_RDDATA, 32'h0, `RESP_SLVERR);
		#1;
		axil_reset_n = 2'h2;
		@(posedge clock);
		#1;
		axil_reset_n = 2'h3;
		axi(0, `OFS_ERROR, 32'h0, `RESP_OKAY);
		#1;
		reset_n = 1'b0;
		repeat (3) @(posedge clock);
		#1;
		reset_n = 1'b1;
		axi(0, `OFS_STATUS, 32'h1, `RESP_OKAY);
		if (sq.size() != 0) begin
			n_errors++;
			$display("mismatch at %0t: stream words missing", $time);
		end
		final_report();
	end
endmodule : test_dual_port_mailbox

`default_nettype wire
